// ===== verification/can_engine_model.sv
// Purpose: protocol engine and far bus nodes, as frame event pulses
// Assumes: pulses launched right after a rising edge
// Notes:   each task leaves one quiet cycle so pulses never merge
`timescale 1ns/1ps
module can_engine_model (
   input wire logic hclk,
   output logic frame_start,
   output logic crc_start,
   output logic tx_done,
   output logic tx_fail,
   output logic bus_resume,
   output logic [14:0] remote_hit,
   output logic [14:0] rx_store,
   output logic can_error,
   output logic [7:0] error_bits
);
   logic [4:0] ev_r = 5'h00;
   assign {frame_start, crc_start, tx_done, tx_fail, bus_resume} = ev_r;
   initial begin
      remote_hit = 15'h0000;
      rx_store = 15'h0000;
      can_error = 1'b0;
      error_bits = 8'h00;
   end
   // frame order, fail and resume, back to back starts
   task automatic pulse(input logic [4:0] m, input int gap);
      ev_r <= m;
      @(posedge hclk);
      ev_r <= 5'h00;
      repeat (gap + 1) @(posedge hclk);
   endtask
   task automatic hit(input logic [14:0] r, input logic [14:0] s);
      remote_hit <= r;
      rx_store <= s;
      @(posedge hclk);
      remote_hit <= 15'h0000;
      rx_store <= 15'h0000;
      @(posedge hclk);
   endtask
   // diagnosis lines are not held once the error pulse is gone
   task automatic err(input logic [7:0] b);
      can_error <= 1'b1;
      error_bits <= b;
      @(posedge hclk);
      can_error <= 1'b0;
      error_bits <= ~b;
      @(posedge hclk);
   endtask
endmodule

// ===== verification/can_tx_sva.sv
// Purpose: port assertions of the can transmit scheduler
// Assumes: engine pulses keep frame order
// Notes:   bound to the top module below the checker
`timescale 1ns/1ps
module can_tx_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic frame_start,
   input wire logic crc_start,
   input wire logic tx_done,
   input wire logic tx_fail,
   input wire logic bus_resume,
   input wire logic [14:0] remote_hit,
   input wire logic [14:0] rx_store,
   input wire logic can_error,
   input wire logic tx_req,
   input wire logic [3:0] tx_buf,
   input wire logic irq,
   input wire logic wake
);
   logic run_r;
   logic hold_r;
   logic ev;
   assign ev = tx_done || can_error || (|rx_store) || (|remote_hit);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----
   // frame and fail windows
   // ----
   // a frame open before its crc field leaves no room to schedule
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) run_r <= 1'b0;
      else if (frame_start && tx_req) run_r <= 1'b1;
      else if (crc_start || tx_fail) run_r <= 1'b0;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hold_r <= 1'b0;
      else if (tx_fail) hold_r <= 1'b1;
      else if (bus_resume) hold_r <= 1'b0;
   end
   // ----
   // properties
   // ----
   property p_start_takes; frame_start && tx_req |=> !tx_req; endproperty
   a_start_takes: assert property (p_start_takes)
      else $error("scheduled buffer kept after frame start");
   property p_no_early; run_r |-> !tx_req; endproperty
   a_no_early: assert property (p_no_early)
      else $error("buffer scheduled before crc field");
   property p_fail_drop; tx_fail |=> !tx_req; endproperty
   a_fail_drop: assert property (p_fail_drop)
      else $error("schedule kept after failed frame");
   property p_fail_hold; hold_r |-> !tx_req; endproperty
   a_fail_hold: assert property (p_fail_hold)
      else $error("buffer scheduled before bus resumed");
   // a back to back start right after the end legally takes the queue
   property p_done_keeps;
      tx_done && tx_req |=> tx_req ##1 (tx_req || $past(frame_start));
   endproperty
   a_done_keeps: assert property (p_done_keeps)
      else $error("queued buffer lost at end of frame");
   property p_range; tx_req |-> tx_buf <= 4'hE; endproperty
   a_range: assert property (p_range)
      else $error("scheduled buffer number out of range");
   property p_wake; wake |-> $past(|rx_store); endproperty
   a_wake: assert property (p_wake)
      else $error("wake pulse without receive event");
   property p_irq; $rose(irq) |-> $past(ev) || $past(ev, 2); endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt raised without an event");
   c_frame: cover property (frame_start && tx_req ##[1:40] tx_done);
   c_fail: cover property (tx_fail ##[1:40] bus_resume);
   c_wake: cover property (wake);
endmodule

bind can_tx_scheduler_and_irq can_tx_sva u_sva (
   .hclk(hclk), .hresetn(hresetn), .frame_start(frame_start),
   .crc_start(crc_start), .tx_done(tx_done), .tx_fail(tx_fail),
   .bus_resume(bus_resume), .remote_hit(remote_hit),
   .rx_store(rx_store), .can_error(can_error), .tx_req(tx_req),
   .tx_buf(tx_buf), .irq(irq), .wake(wake)
);

// ===== verification/testbench.sv
// Purpose: self-checking bench of the can transmit scheduler
// Assumes: zero-wait ahb-lite slave, engine model on the far side
// Notes:   hsize is tied; ce is dropped once around an error pulse
`timescale 1ns/1ps
`include "can_tx_map.svh"
module testbench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout, hresp, crc_start, frame_start, tx_done, tx_fail;
   logic bus_resume, can_error, tx_req, tx_remote, irq, wake;
   logic [14:0] remote_hit, rx_store;
   logic [7:0] error_bits;
   logic [3:0] tx_buf;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   localparam logic [4:0] fr = 5'h10, crc = 5'h08, ok = 5'h04;
   localparam logic [4:0] bad = 5'h02, res = 5'h01;
   always #50 hclk = ~hclk;
   can_tx_scheduler_and_irq u_dut (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .crc_start(crc_start),
      .frame_start(frame_start), .tx_done(tx_done), .tx_fail(tx_fail),
      .bus_resume(bus_resume), .remote_hit(remote_hit),
      .rx_store(rx_store), .can_error(can_error),
      .error_bits(error_bits), .tx_req(tx_req), .tx_buf(tx_buf),
      .tx_remote(tx_remote), .irq(irq), .wake(wake));
   can_engine_model u_eng (
      .hclk(hclk), .frame_start(frame_start), .crc_start(crc_start),
      .tx_done(tx_done), .tx_fail(tx_fail), .bus_resume(bus_resume),
      .remote_hit(remote_hit), .rx_store(rx_store),
      .can_error(can_error), .error_bits(error_bits));
   // ----
   // shared tasks
   // ----
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic xf(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xf(1'b1, a, d, q);
      repeat (3) @(posedge hclk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xf(1'b0, a, 32'h0000_0000, q);
      chk(q, e);
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_single();
      rc(8'h0C, 32'h0000_0000);
      rc(8'h80, 32'h0000_0000);
      wr(`OFS_INT_ENABLE, 32'h0000_0008);
      wr(`OFS_CODE_ENABLE, 32'h0000_FFFF);
      wr(8'h0C, 32'h0000_0008);
      wr(8'h0C, 32'h0000_005C);
      rc(8'h0C, 32'h0000_005D);
      chk(32'(tx_buf), 32'h0000_0003);
      wr(8'h0C, 32'h0000_00FC);
      rc(8'h0C, 32'h0000_005D);
      chk(32'(hresp), 32'h0000_0000);
      u_eng.pulse(fr, 2);
      u_eng.pulse(crc, 2);
      u_eng.pulse(ok, 3);
      rc(8'h0C, 32'h0000_0058);
      rc(`OFS_INT_PENDING, 32'h0000_0008);
      rc(`OFS_STATUS_PEND, 32'h0000_0014);
      chk(32'(irq), 32'h0000_0001);
      wr(`OFS_INT_CLEAR, 32'h0000_0008);
      rc(`OFS_INT_PENDING, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
   endtask
   task automatic t_prio_fail();
      wr(8'h24, 32'h0000_000C);
      u_eng.pulse(fr, 0);
      wr(8'h08, 32'h0000_001C);
      wr(8'h14, 32'h0000_000C);
      chk(32'(tx_req), 32'h0000_0000);
      u_eng.pulse(crc, 2);
      chk(32'(tx_buf), 32'h0000_0005);
      wr(8'h04, 32'h0000_000C);
      chk(32'(tx_buf), 32'h0000_0001);
      rc(8'h14, 32'h0000_000C);
      wr(8'h04, 32'h0000_0008);
      chk(32'(tx_buf), 32'h0000_0005);
      u_eng.pulse(ok, 0);
      chk(32'(tx_req), 32'h0000_0001);
      u_eng.pulse(fr, 0);
      u_eng.pulse(crc, 2);
      u_eng.pulse(bad, 2);
      rc(8'h14, 32'h0000_000C);
      chk(32'(tx_req), 32'h0000_0000);
      u_eng.pulse(res, 2);
      chk(32'(tx_buf), 32'h0000_0005);
      u_eng.pulse(fr, 0);
      u_eng.pulse(crc, 2);
      u_eng.pulse(ok, 0);
      chk(32'(tx_buf), 32'h0000_0002);
      u_eng.pulse(fr, 0);
      u_eng.pulse(crc, 0);
      u_eng.pulse(ok, 2);
      rc(8'h14, 32'h0000_0008);
      rc(8'h08, 32'h0000_0018);
   endtask
   task automatic t_remote();
      wr(8'h1C, 32'h0000_000A);
      chk(32'(tx_req), 32'h0000_0000);
      u_eng.hit(15'h0080, 15'h0000);
      chk(32'(wake), 32'h0000_0000);
      rc(8'h1C, 32'h0000_000F);
      u_eng.pulse(fr, 0);
      u_eng.pulse(crc, 0);
      u_eng.pulse(ok, 2);
      rc(8'h1C, 32'h0000_000A);
      wr(8'h20, 32'h0000_010C);
      chk(32'(tx_remote), 32'h0000_0001);
      u_eng.pulse(fr, 0);
      u_eng.pulse(crc, 0);
      u_eng.pulse(ok, 2);
      rc(8'h20, 32'h0000_0102);
      u_eng.hit(15'h0000, 15'h0100);
      chk(32'(wake), 32'h0000_0001);
      rc(8'h20, 32'h0000_0104);
   endtask
   task automatic t_error();
      wr(`OFS_INT_ENABLE, 32'h0000_8001);
      wr(8'h00, 32'h0000_0002);
      u_eng.hit(15'h0000, 15'h0001);
      u_eng.err(8'h5A);
      rc(`OFS_INT_PENDING, 32'h0000_8001);
      rc(`OFS_ERR_DIAG, 32'h0000_005A);
      rc(`OFS_STATUS_PEND, 32'h0000_0010);
      wr(`OFS_CODE_ENABLE, 32'h0000_0001);
      rc(`OFS_STATUS_PEND, 32'h0000_0011);
      wr(`OFS_CODE_ENABLE, 32'h0000_0000);
      rc(`OFS_STATUS_PEND, 32'h0000_0000);
      // with the enable low the error pulse must leave no trace
      ce <= 1'b0;
      u_eng.err(8'hA5);
      ce <= 1'b1;
      rc(`OFS_ERR_DIAG, 32'h0000_005A);
   endtask
   task automatic finish_test();
      if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // the whole run needs well under a thousand cycles
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_single();
      t_prio_fail();
      t_remote();
      t_error();
      finish_test();
   end
endmodule

// ===== verilog/can_tx_map.svh
// Purpose: offsets, field positions, codes and reset values of the
//          can transmit scheduler and interrupt block
// Assumes: 32-bit ahb-lite words, one aligned word per register
// Notes:   included by its bare name
// Function
// RULE1: busy send buffer: only phase bits 3..1 writable
// RULE2: from crc start, pick best pending buffer
// RULE3: cancel or higher rank replaces scheduled buffer
// RULE4: displaced buffer returns to send_single (code clears only the busy bit, so a 1111b buffer returns to 1110b)
// RULE5: on failure wait resume, reselect, resend
// RULE6: software writes to busy bit ignored
// RULE7: rearbitrate after each frame, back to back
// RULE8: rank is send_rank_field over buffer number
// RULE9: equal rank: lower buffer number wins
// RULE10: software idles buffer, loads, then starts
// RULE11: writing send codes raises transmit request
// RULE12: remote frame triggers automatic data send
// RULE13: success: data to idle, remote to armed
// RULE14: 1110b reads 1111b, then awaits requests
// RULE15: 1010b awaits remote frame before sending
// RULE16: one irq vector, data receive to wake
// RULE17: listed buffer transitions raise interrupts
// RULE18: can error sets error flag and diagnosis
// RULE19: per-source enable, pending cleared by clear mask
// RULE20: winner code 0 none, 0 error, n+1 buffer
// RULE21: error first, then buffers 0 to 14
// RULE22: send_idle 1000b, send_single 1100b
// RULE23: phase bit 3 marks transmit buffer
// RULE24: receive codes 0000b, 0010b, 0100b, busy 0101b
`ifndef CAN_TX_MAP_SVH
`define CAN_TX_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets (low address byte)
// ----------------------------------------------------------------------
`define OFS_BUF_BASE 8'h00
`define OFS_INT_ENABLE 8'h40
`define OFS_INT_PENDING 8'h44
`define OFS_INT_CLEAR 8'h48
`define OFS_CODE_ENABLE 8'h4C
`define OFS_STATUS_PEND 8'h50
`define OFS_ERR_DIAG 8'h54

// ----------------------------------------------------------------------
// buffer_status_word fields
// ----------------------------------------------------------------------
`define POS_PHASE 0
`define POS_RANK 4
`define POS_REMOTE 8
`define POS_ACTIVE 4
`define BIT_ERR 15

// ----------------------------------------------------------------------
// phase codes
// ----------------------------------------------------------------------
`define PH_RX_IDLE 4'h0
`define PH_RX_ARMED 4'h2
`define PH_RX_HOLD 4'h4
`define PH_RX_HOLD_BUSY 4'h5
`define PH_RX_OVER 4'h6
`define PH_SEND_IDLE 4'h8
`define PH_AWAIT_REQ 4'hA
`define PH_SEND_SINGLE 4'hC
`define PH_SEND_AWAIT 4'hE

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_PHASE 4'h0
`define RST_MASK 16'h0000
`define RST_DIAG 8'h00

`endif

// ===== verilog/can_tx_pkg.sv
// Purpose: types shared by the can transmit scheduler
// Assumes: nothing beyond the map header
// Notes:   none
package can_tx_pkg;
   typedef logic [3:0] phase_t;
   typedef enum logic {sched_run, sched_hold} sched_t;
endpackage

// ===== verilog/can_tx_scheduler_and_irq.sv
// Purpose: transmit scheduling, buffer phases and interrupt coding
//          of a 15-buffer can controller, behind an ahb-lite slave
// Assumes: protocol engine on hclk drives the frame event pulses
// Notes:   zero-wait-state slave, always okay
`timescale 1ns/1ps
`include "can_tx_map.svh"

module can_tx_scheduler_and_irq (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic crc_start,
   input wire logic frame_start,
   input wire logic tx_done,
   input wire logic tx_fail,
   input wire logic bus_resume,
   input wire logic [14:0] remote_hit,
   input wire logic [14:0] rx_store,
   input wire logic can_error,
   input wire logic [7:0] error_bits,
   output logic tx_req,
   output logic [3:0] tx_buf,
   output logic tx_remote,
   output logic irq,
   output logic wake
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   can_tx_pkg::phase_t st_r [15];
   logic [3:0] rank_r [15];
   logic [14:0] rmt_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic cur_valid_r;
   logic [3:0] cur_r;
   logic nxt_valid_r;
   logic [3:0] nxt_r;
   logic crc_seen_r;
   can_tx_pkg::sched_t sched_r;
   logic [15:0] ien_r;
   logic [15:0] pend_r;
   logic [15:0] cen_r;
   logic [7:0] diag_r;
   logic [4:0] spw_r;
   logic irq_r;
   logic wake_r;
   logic tx_remote_r;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   function automatic logic is_send_code(input logic [2:0] hi);
      is_send_code = (hi == 3'(`PH_SEND_SINGLE >> 1)) ||
         (hi == 3'(`PH_SEND_AWAIT >> 1));
   endfunction

   // slot 15 of the buffer window is not a buffer
   function automatic logic is_buf_addr(input logic [7:0] a);
      is_buf_addr = (a[7:6] == 2'b00) && (a[5:2] != 4'hF);
   endfunction

   // lowest combined rank wins; scan ascending so ties go to lower n
   function automatic logic [4:0] pick(input logic [14:0] cand,
         input logic [119:0] rk);
      logic [7:0] best;
      logic [4:0] res;
      best = 8'hFF;
      res = 5'h00;
      for (int i = 0; i < 15; i++) begin
         if (cand[i] && ({rk[i*8 +: 4], 4'(i)} < best)) begin // RULE8 RULE9
            best = {rk[i*8 +: 4], 4'(i)};
            res = {1'b1, 4'(i)};
         end
      end
      pick = res;
   endfunction

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   logic acc;
   logic buf_hit;
   logic [3:0] wbuf;
   logic [31:0] rd_data;
   logic [3:0] rbuf;

   assign acc = hsel && htrans[1] && hready;
   assign buf_hit = is_buf_addr(wr_addr_r);
   assign wbuf = wr_addr_r[5:2];
   assign rbuf = haddr[5:2];

   always_comb begin
      rd_data = 32'h0000_0000;
      if (is_buf_addr(haddr[7:0])) begin
         rd_data[`POS_PHASE +: 4] = st_r[rbuf];
         rd_data[`POS_RANK +: 4] = rank_r[rbuf];
         rd_data[`POS_REMOTE] = rmt_r[rbuf];
      end else if (haddr[7:0] == `OFS_INT_ENABLE) begin
         rd_data[15:0] = ien_r;
      end else if (haddr[7:0] == `OFS_INT_PENDING) begin
         rd_data[15:0] = pend_r;
      end else if (haddr[7:0] == `OFS_CODE_ENABLE) begin
         rd_data[15:0] = cen_r;
      end else if (haddr[7:0] == `OFS_STATUS_PEND) begin
         rd_data[4:0] = spw_r;
      end else if (haddr[7:0] == `OFS_ERR_DIAG) begin
         rd_data[7:0] = diag_r;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
         hreadyout_r <= 1'b0;
      end else if (ce) begin
         hreadyout_r <= 1'b1;
         wr_pend_r <= acc && hwrite;
         if (acc) begin
            wr_addr_r <= haddr[7:0];
         end
         if (acc && !hwrite) begin
            hrdata_r <= rd_data;
         end
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = 1'b0;

   // ----------------------------------------------------------------
   // selection and per-buffer events
   // ----------------------------------------------------------------
   logic [14:0] cand;
   logic [119:0] rk_flat;
   logic [4:0] best;
   logic sel_open;
   logic take;
   logic [14:0] sw_wr;
   logic cancel;

   always_comb begin
      rk_flat = 120'h0;
      for (int i = 0; i < 15; i++) begin
         cand[i] = (st_r[i] == `PH_SEND_SINGLE) ||
            (st_r[i] == `PH_SEND_AWAIT); // RULE11
         rk_flat[i*8 +: 4] = rank_r[i];
         sw_wr[i] = wr_pend_r && buf_hit && (wbuf == 4'(i));
      end
   end

   assign best = pick(cand, rk_flat);
   // window: bus idle, or crc of current frame reached
   assign sel_open = (sched_r == can_tx_pkg::sched_run) &&
      (!cur_valid_r || crc_seen_r) && !frame_start; // RULE2 RULE7
   assign take = sel_open && best[4] && (!nxt_valid_r ||
      ({rank_r[best[3:0]], best[3:0]} <
       {rank_r[nxt_r], nxt_r})); // RULE3
   assign cancel = nxt_valid_r && sw_wr[nxt_r] &&
      !is_send_code(hwdata[3:1]); // RULE3

   logic [14:0] done_n;
   logic [14:0] fail_n;
   logic [14:0] take_n;
   logic [14:0] drop_n;
   logic [14:0] rmt_n;
   logic [14:0] rx_n;
   logic [14:0] ev_n;

   always_comb begin
      for (int i = 0; i < 15; i++) begin
         done_n[i] = tx_done && cur_valid_r && (cur_r == 4'(i));
         fail_n[i] = tx_fail && ((cur_valid_r && (cur_r == 4'(i))) ||
            (nxt_valid_r && (nxt_r == 4'(i))));
         take_n[i] = take && (best[3:0] == 4'(i));
         drop_n[i] = take && nxt_valid_r && (nxt_r == 4'(i));
         rmt_n[i] = remote_hit[i] && (st_r[i] == `PH_AWAIT_REQ);
         rx_n[i] = rx_store[i] && ((st_r[i] == `PH_RX_ARMED) ||
            (st_r[i] == `PH_RX_HOLD));
         ev_n[i] = rx_n[i] || rmt_n[i] || (done_n[i] &&
            ((st_r[i] == (`PH_SEND_SINGLE | 4'h1)) ||
             (st_r[i] == (`PH_SEND_AWAIT | 4'h1)))); // RULE17
      end
   end

   // ----------------------------------------------------------------
   // buffer phases; hardware events win over a same-cycle write
   // ----------------------------------------------------------------
   generate
      for (genvar g = 0; g < 15; g++) begin : g_buf
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               st_r[g] <= `RST_PHASE;
               rank_r[g] <= 4'h0;
               rmt_r[g] <= 1'b0;
            end else if (ce) begin
               if (done_n[g]) begin
                  if (st_r[g] == (`PH_SEND_SINGLE | 4'h1)) begin
                     st_r[g] <= rmt_r[g] ? `PH_RX_ARMED :
                        `PH_SEND_IDLE; // RULE13 RULE22
                  end else if (st_r[g] == (`PH_SEND_AWAIT | 4'h1)) begin
                     st_r[g] <= `PH_AWAIT_REQ; // RULE14
                  end else begin
                     st_r[g] <= {st_r[g][3:1], 1'b0};
                  end
               end else if (fail_n[g] || drop_n[g]) begin
                  st_r[g] <= {st_r[g][3:1], 1'b0}; // RULE4 RULE5
               end else if (take_n[g]) begin
                  st_r[g] <= {st_r[g][3:1], 1'b1}; // RULE2 RULE14
               end else if (rmt_n[g]) begin
                  st_r[g] <= `PH_SEND_AWAIT; // RULE12 RULE15
               end else if (rx_n[g]) begin
                  st_r[g] <= (st_r[g] == `PH_RX_ARMED) ? `PH_RX_HOLD :
                     `PH_RX_OVER; // RULE24
               end else if (sw_wr[g]) begin
                  if (cancel && (nxt_r == 4'(g))) begin
                     st_r[g] <= {hwdata[3:1], 1'b0}; // RULE3
                  end else begin
                     st_r[g] <= {hwdata[3:1], st_r[g][0]}; // RULE6
                  end
                  if (!(st_r[g][3] && st_r[g][0])) begin // RULE1 RULE23
                     rank_r[g] <= hwdata[`POS_RANK +: 4];
                     rmt_r[g] <= hwdata[`POS_REMOTE];
                  end
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // scheduler: current frame and the one queued behind it
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_valid_r <= 1'b0;
         cur_r <= 4'h0;
         nxt_valid_r <= 1'b0;
         nxt_r <= 4'h0;
         crc_seen_r <= 1'b0;
         sched_r <= can_tx_pkg::sched_run;
      end else if (ce) begin
         case (sched_r)
            can_tx_pkg::sched_run: begin
               if (tx_fail) begin
                  cur_valid_r <= 1'b0; // RULE5
                  nxt_valid_r <= 1'b0;
                  crc_seen_r <= 1'b0;
                  sched_r <= can_tx_pkg::sched_hold;
               end else if (frame_start && nxt_valid_r) begin
                  cur_valid_r <= 1'b1;
                  cur_r <= nxt_r;
                  nxt_valid_r <= 1'b0;
                  crc_seen_r <= 1'b0;
               end else begin
                  if (tx_done) begin
                     cur_valid_r <= 1'b0; // RULE7
                     crc_seen_r <= 1'b0;
                  end else if (crc_start && cur_valid_r) begin
                     crc_seen_r <= 1'b1;
                  end
                  if (take) begin
                     nxt_valid_r <= 1'b1;
                     nxt_r <= best[3:0];
                  end else if (cancel) begin
                     nxt_valid_r <= 1'b0;
                  end
               end
            end
            can_tx_pkg::sched_hold: begin
               if (bus_resume) begin
                  sched_r <= can_tx_pkg::sched_run; // RULE5
               end
            end
            default: begin
               sched_r <= can_tx_pkg::sched_run;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_remote_r <= 1'b0;
      end else if (ce) begin
         tx_remote_r <= rmt_r[nxt_r];
      end
   end

   assign tx_req = nxt_valid_r;
   assign tx_buf = nxt_r;
   assign tx_remote = tx_remote_r;

   // ----------------------------------------------------------------
   // interrupt flags; a set wins over a clear in the same cycle
   // ----------------------------------------------------------------
   logic wr_clr;
   logic [15:0] set_v;

   assign wr_clr = wr_pend_r && (wr_addr_r == `OFS_INT_CLEAR);
   assign set_v = {can_error, ev_n} & ien_r; // RULE19

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ien_r <= `RST_MASK;
         cen_r <= `RST_MASK;
         pend_r <= `RST_MASK;
         diag_r <= `RST_DIAG;
      end else if (ce) begin
         if (wr_pend_r && (wr_addr_r == `OFS_INT_ENABLE)) begin
            ien_r <= hwdata[15:0];
         end
         if (wr_pend_r && (wr_addr_r == `OFS_CODE_ENABLE)) begin
            cen_r <= hwdata[15:0];
         end
         pend_r <= (pend_r & ~(wr_clr ? hwdata[15:0] : 16'h0000)) |
            set_v; // RULE18 RULE19
         diag_r <= (diag_r & ~((wr_pend_r &&
            (wr_addr_r == `OFS_ERR_DIAG)) ? hwdata[7:0] : 8'h00)) |
            (can_error ? error_bits : 8'h00); // RULE18
      end
   end

   // ----------------------------------------------------------------
   // winner code, vector and wake
   // ----------------------------------------------------------------
   logic [15:0] coded;
   logic [4:0] spw_nxt;

   assign coded = pend_r & cen_r;

   always_comb begin
      spw_nxt = 5'h00; // RULE20
      for (int i = 14; i >= 0; i--) begin
         if (coded[i]) begin
            spw_nxt = {1'b1, 4'(i + 1)}; // RULE21
         end
      end
      if (coded[`BIT_ERR]) begin
         spw_nxt = {1'b1, 4'h0}; // RULE21
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         spw_r <= 5'h00;
         irq_r <= 1'b0;
         wake_r <= 1'b0;
      end else if (ce) begin
         spw_r <= spw_nxt; // RULE20
         irq_r <= |pend_r; // RULE16
         wake_r <= |rx_n; // RULE16
      end
   end

   assign irq = irq_r;
   assign wake = wake_r;

endmodule
